// [pwmg_regs.svh]
// register map, field positions, reset values and timing counts of the pulse generator
// assumes inclusion by bare name from the package and the top module
`ifndef PWMG_REGS_SVH
`define PWMG_REGS_SVH

`define PWMG_ADDR_W 4
`define PWMG_OFS_HIGH 4'h0
`define PWMG_OFS_LOW 4'h4
`define PWMG_OFS_CFG 4'h8

`define PWMG_CNT_W 16
`define PWMG_RST_HIGH 16'h0000
`define PWMG_RST_LOW 16'hffff

`define PWMG_CFG_W 7
`define PWMG_RST_CFG 7'h00
`define PWMG_CFG_EN 0
`define PWMG_CFG_CLKSEL 1
`define PWMG_CFG_INV 2
`define PWMG_CFG_PDIV_LO 3
`define PWMG_CFG_PDIV_HI 6

`define PWMG_RESP_OKAY 2'b00
`define PWMG_RESP_SLVERR 2'b10

// system clock and the slow tick derived from it
`define PWMG_CLK_PERIOD_NS 10
`define PWMG_SLOW_PERIOD_NS 10000
`define PWMG_SLOW_CYCLES (`PWMG_SLOW_PERIOD_NS / `PWMG_CLK_PERIOD_NS)
`define PWMG_SLOW_CNT_W 10

`endif

// [pwmg_pkg.sv]
// types shared by the pulse generator
// assumes pwmg_regs.svh is on the include path
`include "pwmg_regs.svh"

package pwmg_pkg;
    typedef enum logic {
        PWMG_PH_OFF = 1'b0,
        PWMG_PH_ON = 1'b1
    } pwmg_phase_t;

    typedef logic [`PWMG_CNT_W-1:0] pwmg_cnt_t;
endpackage

// [pwmg_top.sv]
// pulse-width generator with on/off phase counts, config and an AXI4-Lite slave
// assumes one 100 MHz clock; the slow source is an enable pulse derived from it
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "pwmg_regs.svh"

// Notes on behaviour
// - off phase lasts low count plus one ticks
// - zero low count holds output fully on
// - low count 16-bit rw, resets to ones
// - 16-bit down counter, source set by bit1
// - prescaler divides selected clock by value+1
// - clock select one slow, zero fast
// - invert bit makes on level low
// - disabled holds counters reset, state off
// - disabled output sits at inactive level
// - count registers not reset by enable; disabled loads pending counts at once
// - disable holds slow and prescaler counters at zero, enable resets zero
// - on phase lasts high count plus one ticks
// - zero high, nonzero low holds fully off
// - counts load from holding after four bytes
// - sleep zeroes counters, forces state off
module pwmg_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sleep_req,
    input wire logic awvalid,
    output logic awready,
    input wire logic [`PWMG_ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [`PWMG_ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic pwm_out
);
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic pwm_out_r;
    logic [`PWMG_ADDR_W-1:0] waddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic wr_fire;

    pwmg_pkg::pwmg_cnt_t high_phase_count_r;
    pwmg_pkg::pwmg_cnt_t low_phase_count_r;
    logic [`PWMG_CFG_W-1:0] cfg_r;
    logic [7:0] hold_r [4];
    logic [3:0] hold_full_r;
    logic load_now;
    pwmg_pkg::pwmg_cnt_t high_nxt;
    pwmg_pkg::pwmg_cnt_t low_nxt;

    pwmg_pkg::pwmg_phase_t phase_r;
    pwmg_pkg::pwmg_cnt_t cnt_r;
    logic [`PWMG_SLOW_CNT_W-1:0] slow_cnt_r;
    logic slow_tick;
    logic src_tick;
    logic [3:0] pdiv_cnt_r;
    logic tick;
    logic enabled;
    logic inv;
    logic full_on;
    logic full_off;
    logic off_done;
    logic out_nxt;

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign pwm_out = pwm_out_r;

    // write side: address and data latched independently, any order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            waddr_r <= '0;
        end else if (awvalid && awready_r) begin
            awready_r <= 1'b0;
            waddr_r <= awaddr;
        end else if (bvalid_r && bready) begin
            awready_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_r <= 1'b1;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else if (wvalid && wready_r) begin
            wready_r <= 1'b0;
            wdata_r <= wdata;
            wstrb_r <= wstrb;
        end else if (bvalid_r && bready) begin
            wready_r <= 1'b1;
        end
    end

    assign wr_fire = !awready_r && !wready_r && !bvalid_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= `PWMG_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            if (waddr_r == `PWMG_OFS_HIGH || waddr_r == `PWMG_OFS_LOW
                    || waddr_r == `PWMG_OFS_CFG) begin
                bresp_r <= `PWMG_RESP_OKAY;
            end else begin
                bresp_r <= `PWMG_RESP_SLVERR;
            end
        end else if (bvalid_r && bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // read side; visible values only, never the holding bytes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= `PWMG_RESP_OKAY;
        end else if (arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= `PWMG_RESP_OKAY;
            unique case (araddr)
                `PWMG_OFS_HIGH: rdata_r <= {16'h0000, high_phase_count_r};
                `PWMG_OFS_LOW: rdata_r <= {16'h0000, low_phase_count_r};
                `PWMG_OFS_CFG: rdata_r <= {25'h000_0000, cfg_r};
                default: begin
                    rdata_r <= '0;
                    rresp_r <= `PWMG_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_r && rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    // config: only bits 6:0 exist
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_r <= `PWMG_RST_CFG;
        end else if (wr_fire && waddr_r == `PWMG_OFS_CFG && wstrb_r[0]) begin
            cfg_r <= wdata_r[`PWMG_CFG_W-1:0];
        end
    end

    assign enabled = cfg_r[`PWMG_CFG_EN];
    assign inv = cfg_r[`PWMG_CFG_INV];

    // holding bytes: 0,1 feed the high count, 2,3 the low count
    for (genvar i = 0; i < 4; i++) begin : g_hold
        localparam logic [`PWMG_ADDR_W-1:0] OFS = (i < 2) ? `PWMG_OFS_HIGH : `PWMG_OFS_LOW;
        logic wr_byte;
        assign wr_byte = wr_fire && waddr_r == OFS && wstrb_r[i % 2];
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                hold_r[i] <= 8'h00;
                hold_full_r[i] <= 1'b0;
            end else if (wr_byte) begin
                hold_r[i] <= wdata_r[(i % 2) * 8 +: 8];
                hold_full_r[i] <= 1'b1;
            end else if (load_now) begin
                hold_full_r[i] <= 1'b0;
            end
        end
    end

    assign full_on = low_phase_count_r == '0;
    assign full_off = high_phase_count_r == '0 && !full_on;
    assign off_done = tick && phase_r == pwmg_pkg::PWMG_PH_OFF && cnt_r == '0;
    // idle generator never finishes an off phase, so it takes new counts at once
    assign load_now = &hold_full_r && (full_on || off_done || !enabled || sleep_req);
    assign high_nxt = load_now ? {hold_r[1], hold_r[0]} : high_phase_count_r;
    assign low_nxt = load_now ? {hold_r[3], hold_r[2]} : low_phase_count_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            high_phase_count_r <= `PWMG_RST_HIGH;
            low_phase_count_r <= `PWMG_RST_LOW;
        end else if (load_now) begin
            high_phase_count_r <= high_nxt;
            low_phase_count_r <= low_nxt;
        end
    end

    // slow source as an enable pulse; held at zero while idle
    always_ff @(posedge aclk) begin
        if (!aresetn || !enabled || sleep_req) begin
            slow_cnt_r <= '0;
        end else if (slow_cnt_r == `PWMG_SLOW_CNT_W'(`PWMG_SLOW_CYCLES - 1)) begin
            slow_cnt_r <= '0;
        end else begin
            slow_cnt_r <= slow_cnt_r + `PWMG_SLOW_CNT_W'(1);
        end
    end

    assign slow_tick = slow_cnt_r == `PWMG_SLOW_CNT_W'(`PWMG_SLOW_CYCLES - 1);
    assign src_tick = cfg_r[`PWMG_CFG_CLKSEL] ? slow_tick : 1'b1;
    assign tick = src_tick && pdiv_cnt_r == cfg_r[`PWMG_CFG_PDIV_HI:`PWMG_CFG_PDIV_LO];

    always_ff @(posedge aclk) begin
        if (!aresetn || !enabled || sleep_req) begin
            pdiv_cnt_r <= '0;
        end else if (tick) begin
            pdiv_cnt_r <= '0;
        end else if (src_tick) begin
            pdiv_cnt_r <= pdiv_cnt_r + 4'h1;
        end
    end

    // phase machine: counter reaches zero, one more tick flips phase
    always_ff @(posedge aclk) begin
        if (!aresetn || !enabled || sleep_req) begin
            phase_r <= pwmg_pkg::PWMG_PH_OFF;
            cnt_r <= '0;
        end else if (tick) begin
            if (cnt_r != '0) begin
                cnt_r <= cnt_r - 16'h0001;
            end else if (phase_r == pwmg_pkg::PWMG_PH_OFF) begin
                phase_r <= pwmg_pkg::PWMG_PH_ON;
                cnt_r <= high_nxt;
            end else begin
                phase_r <= pwmg_pkg::PWMG_PH_OFF;
                cnt_r <= low_nxt;
            end
        end
    end

    always_comb begin
        if (!enabled || sleep_req) begin
            out_nxt = inv;
        end else if (full_on) begin
            out_nxt = !inv;
        end else if (full_off) begin
            out_nxt = inv;
        end else begin
            out_nxt = (phase_r == pwmg_pkg::PWMG_PH_ON) ? !inv : inv;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_out_r <= 1'b0;
        end else begin
            pwm_out_r <= out_nxt;
        end
    end
endmodule

// [pwmg_load.sv]
// load on the pulse pin: measures the last high and low run lengths
// assumes the pin is sampled on the system clock rising edge
`timescale 1ns/100ps
module pwmg_load (
    input wire logic aclk,
    input wire logic pwm_in,
    output int hi_len,
    output int lo_len
);
    int run = 0;
    logic last = 1'b0;
    initial begin
        hi_len = 0;
        lo_len = 0;
    end
    // a run is only recorded when it ends, so the one still in progress is not reported
    always @(posedge aclk) begin
        if (pwm_in !== last) begin
            if (last) hi_len <= run;
            else lo_len <= run;
            run <= 1;
        end else begin
            run <= run + 1;
        end
        last <= pwm_in;
    end
endmodule

// [pwmg_checker.sv]
// bus handshake and output checks for the pulse generator
// assumes it is bound to pwmg_top, one clock domain
`timescale 1ns/100ps
`include "pwmg_regs.svh"
module pwmg_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sleep_req,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [`PWMG_ADDR_W-1:0] araddr,
    input wire logic rvalid,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic pwm_out
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence b_done;
        bvalid && bready ##1 !bvalid && awready && wready;
    endsequence
    chk_write_answer: assert property (wr_taken |-> ##[1:2] bvalid)
        else $error("write response missing");
    chk_b_release: assert property (bvalid && bready |-> b_done)
        else $error("write channel not released");
    chk_aw_blocked: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while response pending");
    chk_ar_blocked: assert property (rvalid |-> !arready)
        else $error("read taken while data pending");
    chk_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read data late");
    chk_rd_unmapped: assert property (arvalid && arready
        && !(araddr inside {4'h0, 4'h4, 4'h8}) |=> rresp == 2'h2 && rdata == 32'h0)
        else $error("unmapped read not refused");
    chk_cfg_reserved: assert property (arvalid && arready && araddr == 4'h8
        |=> rdata[31:7] == 25'h0)
        else $error("reserved config bits not zero");
    chk_sleep_quiet: assert property (sleep_req [*4] |-> $stable(pwm_out))
        else $error("output moves during sleep");
endmodule
bind pwmg_top pwmg_checker u_chk (.aclk, .aresetn, .sleep_req, .awvalid, .awready,
    .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .araddr, .rvalid, .rdata,
    .rresp, .pwm_out);

// [pwm_offtime_and_config_tb.sv]
// self-checking bench for the pulse generator registers and output
// assumes pwmg_top, pwmg_load and the bound checker are compiled first
`timescale 1ns/100ps
`include "pwmg_regs.svh"
module pwm_offtime_and_config_tb;
    logic aclk, aresetn, sleep_req, awvalid, wvalid, bready, arvalid, rready;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata;
    wire logic awready, wready, bvalid, arready, rvalid, pwm_out;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    int hi_len, lo_len;
    int mismatches = 0;
    int checks = 0;
    pwmg_top dut (.aclk, .aresetn, .sleep_req, .awvalid, .awready, .awaddr,
        .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
        .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
        .pwm_out);
    pwmg_load u_load (.aclk, .pwm_in(pwm_out), .hi_len, .lo_len);
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
            input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        chk("rdata", exp, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    // disable first so the counts load at once instead of after an off phase
    task automatic pwm_case(input logic [31:0] hc, input logic [31:0] lc,
            input logic [31:0] cf, input int cyc);
        wr(`PWMG_OFS_CFG, 32'h0, 4'hf, 2'h0);
        wr(`PWMG_OFS_HIGH, hc, 4'h3, 2'h0);
        wr(`PWMG_OFS_LOW, lc, 4'h3, 2'h0);
        wr(`PWMG_OFS_CFG, cf, 4'h1, 2'h0);
        repeat (cyc) @(posedge aclk);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // slow-clock cases need about 16200 cycles, the rest well under 2000
    initial begin
        #300000;
        mismatches++;
        results();
    end
    initial begin
        {aresetn, sleep_req, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
        {awaddr, araddr, wstrb, wdata} = 44'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`PWMG_OFS_LOW, 32'h0000_ffff, 2'h0);
        rd(`PWMG_OFS_CFG, 32'h0, 2'h0);
        rd(`PWMG_OFS_HIGH, 32'h0, 2'h0);
        rd(4'hc, 32'h0, 2'h2);
        wr(4'hc, 32'h0000_0007, 4'hf, 2'h2);
        wr(`PWMG_OFS_LOW, 32'hffff_0002, 4'hf, 2'h0);
        wr(`PWMG_OFS_HIGH, 32'h0000_0001, 4'h3, 2'h0);
        rd(`PWMG_OFS_LOW, 32'h0000_0002, 2'h0);
        wr(`PWMG_OFS_HIGH, 32'h0000_0005, 4'h3, 2'h0);
        rd(`PWMG_OFS_HIGH, 32'h0000_0001, 2'h0);
        wr(`PWMG_OFS_LOW, 32'h0000_0003, 4'h3, 2'h0);
        rd(`PWMG_OFS_HIGH, 32'h0000_0005, 2'h0);
        wr(`PWMG_OFS_CFG, 32'hffff_ff80, 4'hf, 2'h0);
        rd(`PWMG_OFS_CFG, 32'h0, 2'h0);
        pwm_case(1, 2, 32'h01, 40);
        chk("high run", 2, hi_len);
        chk("low run", 3, lo_len);
        pwm_case(1, 2, 32'h79, 400);
        chk("high run", 32, hi_len);
        chk("low run", 48, lo_len);
        pwm_case(1, 2, 32'h05, 40);
        chk("high run", 3, hi_len);
        chk("low run", 2, lo_len);
        pwm_case(1, 2, 32'h03, 12000);
        chk("high run", 2000, hi_len);
        chk("low run", 3000, lo_len);
        wr(`PWMG_OFS_HIGH, 32'h0000_0002, 4'h3, 2'h0);
        wr(`PWMG_OFS_LOW, 32'h0000_0001, 4'h3, 2'h0);
        rd(`PWMG_OFS_HIGH, 32'h0000_0001, 2'h0);
        // still in an on phase; new counts wait for the off phase ending near 16000
        repeat (4100) @(posedge aclk);
        rd(`PWMG_OFS_HIGH, 32'h0000_0002, 2'h0);
        rd(`PWMG_OFS_LOW, 32'h0000_0001, 2'h0);
        pwm_case(1, 0, 32'h01, 20);
        chk("full on", 1, {31'h0, pwm_out});
        // disabling from full on with invert set: an ignored enable would show 0
        wr(`PWMG_OFS_CFG, 32'h0000_0004, 4'h1, 2'h0);
        repeat (5) @(posedge aclk);
        chk("disabled", 1, {31'h0, pwm_out});
        pwm_case(0, 1, 32'h05, 20);
        chk("full off", 1, {31'h0, pwm_out});
        // sleep from full on, so an ignored sleep request would leave the pin high
        pwm_case(1, 0, 32'h01, 10);
        sleep_req <= 1'b1;
        repeat (6) @(posedge aclk);
        chk("asleep", 0, {31'h0, pwm_out});
        sleep_req <= 1'b0;
        rd(`PWMG_OFS_LOW, 32'h0000_0000, 2'h0);
        chk("awake", 1, {31'h0, pwm_out});
        results();
    end
endmodule
